// *** dcs_params.svh ***
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

`define DCS_OFF_CTRL     12'h100
`define DCS_OFF_STAT     12'h104
`define DCS_OFF_CNT      12'h110
`define DCS_OFF_CRLD     12'h11C

`define DCS_CTRL_RESET   32'h00000000
`define DCS_CTRL_MASK    32'hDF77FFFF
`define DCS_CNT_MASK     32'h00FFFFFF

`define DCS_B_COUNT_ZERO_IRQ_ENABLE     31
`define DCS_B_DISABLE_IRQ_ENABLE     30
`define DCS_B_PRESC_HI   15
`define DCS_B_PRESC_LO   14
`define DCS_B_PER_HI     13
`define DCS_B_PER_LO     11
`define DCS_B_WAIT       10
`define DCS_B_REQ_HI     9
`define DCS_B_REQ_LO     4
`define DCS_B_PRI_HI     3
`define DCS_B_PRI_LO     2
`define DCS_B_RLD_EN     1
`define DCS_B_EN         0

`define DCS_S_TO         6
`define DCS_S_BERR       4
`define DCS_S_RLD        3
`define DCS_S_CTZ        2
`define DCS_S_PEND       1
`define DCS_S_ACT        0

`define DCS_PRESC_SH1    8
`define DCS_PRESC_SH2    16
`define DCS_PRESC_SH3    24
`define DCS_TO_BASE_SH   2
`define DCS_MAX_CH       8

`endif

// *** dcs_pkg.sv ***
`include "dcs_params.svh"

package dcs_pkg;

    typedef enum logic [0:0] {
        DCS_IDLE = 1'b0,
        DCS_RUN  = 1'b1
    } dcs_chan_st_t;

    typedef struct packed {
        logic [31:0]  ctrl;
        logic         to_flag;
        logic         berr_flag;
        logic         rld_flag;
        logic         ctz_flag;
        logic         dis_flag;
        logic         pend;
        dcs_chan_st_t active;
        logic         started;
        logic [23:0]  cnt;
        logic [23:0]  cnt_rld;
        logic [23:0]  pre;
        logic [9:0]   tmr;
        logic [2:0]   rr_ptr;
        logic [7:0]   grant;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         chan_req;
        logic         reload_pulse;
    } dcs_state_t;

endpackage

// *** dcs_channel.sv ***
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "dcs_params.svh"

// How it works
// RULE_01: Period code selects 4 to 512 timer ticks.
// RULE_02: Wait bit defers timer start until request.
// RULE_03: Request select picks the channel request line.
// RULE_04: Priority code 0 highest, 3 lowest.
// RULE_05: Equal priorities are served round-robin.
// RULE_06: Reload enabled count zero reloads the count from the reload register.
// RULE_07: Enable clears when active status falls.
// RULE_08: Timer expiry sets timeout flag, write one clears.
// RULE_09: Bus abort sets error flag, disables channel.
// RULE_10: Every reload sets the reload flag.
// RULE_11: Exhausted count sets count zero flag.
// RULE_12: Pending bit shows an outstanding interrupt.
// RULE_13: Active bit shows channel running.
// RULE_14: Software preserves reserved status bits.
// RULE_15: Count zero with enable raises pending.
// RULE_16: Active fall with enable raises pending.
// RULE_17: Prescale code 0 stops timer, others divide.
// RULE_18: Count drops by transfer width, zero ends.
// RULE_19: Delayed start waits for selected request.
// RULE_20: Pending is OR of sticky flags, timeout and error ungated.
module dcs_channel
    import dcs_pkg::*;
#(
    parameter int NCH    = 8,
    parameter int CH_IDX = 0
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [63:0]       req_vec,
    input  wire logic              xfer_done,
    input  wire logic [1:0]        xfer_width,
    input  wire logic              ahb_abort,
    input  wire logic [NCH-1:0]    peer_req,
    input  wire logic [2*NCH-1:0]  peer_pri,
    output logic                   chan_req,
    output logic                   chan_active,
    output logic                   reload_pulse,
    output logic [NCH-1:0]         grant
);

    generate
        if (NCH < 1 || NCH > `DCS_MAX_CH || CH_IDX < 0 || CH_IDX >= NCH) begin : g_bad
            $error("dcs_channel: NCH must be 1 to 8 and CH_IDX below NCH.");
        end
    endgenerate

    dcs_state_t st;
    dcs_state_t next_st;

    // Picks one request: best level first, then first at or after the pointer.
    function automatic logic [7:0] dcs_arb(input logic [7:0] r, input logic [15:0] p,
                                           input logic [2:0] ptr);
        logic [7:0] g;
        logic       done;
        int         idx;
        g    = '0;
        done = 1'b0;
        idx  = 0;
        for (int l = 0; l < 4; l++) begin
            for (int k = 0; k < NCH; k++) begin
                idx = (int'(ptr) + k) % NCH;
                if (!done && r[idx] && p[2*idx +: 2] == 2'(l)) begin
                    g[idx] = 1'b1;
                    done   = 1'b1;
                end
            end
        end
        return g;
    endfunction

    // One tick of the prescaled timer clock.
    function automatic logic dcs_tick(input logic [1:0] sel, input logic [23:0] pre);
        logic t;
        unique case (sel)
            2'h0: t = 1'b0;
            2'h1: t = &pre[`DCS_PRESC_SH1-1:0];
            2'h2: t = &pre[`DCS_PRESC_SH2-1:0];
            2'h3: t = &pre[`DCS_PRESC_SH3-1:0];
        endcase
        return t;
    endfunction

    // Read view of one register word.
    function automatic logic [31:0] dcs_rd(input dcs_state_t s, input logic [11:0] a);
        logic [31:0] d;
        d = '0;
        unique case (a)
            `DCS_OFF_CTRL: d = s.ctrl;
            `DCS_OFF_STAT: begin
                d[`DCS_S_TO]   = s.to_flag;
                d[`DCS_S_BERR] = s.berr_flag;
                d[`DCS_S_RLD]  = s.rld_flag;
                d[`DCS_S_CTZ]  = s.ctz_flag;
                d[`DCS_S_PEND] = s.pend;
                d[`DCS_S_ACT]  = s.active;
            end
            `DCS_OFF_CNT:  d = {8'h00, s.cnt};
            `DCS_OFF_CRLD: d = {8'h00, s.cnt_rld};
            default:       d = '0;
        endcase
        return d;
    endfunction

    logic        wr_en;
    logic        wr_stat;
    logic        sel_req;
    logic        xfer;
    logic        ctz_ev;
    logic        abort_ev;
    logic        fall_ev;
    logic [23:0] dec;
    logic [9:0]  to_lim;
    logic        tick;
    logic        pend_calc;
    logic [7:0]  arb_r;
    logic [15:0] arb_p;

    always_comb begin
        next_st              = st;
        next_st.reload_pulse = 1'b0;
        wr_en    = psel & penable & st.pready & pwrite;
        wr_stat  = wr_en && paddr == `DCS_OFF_STAT;
        sel_req  = req_vec[st.ctrl[`DCS_B_REQ_HI:`DCS_B_REQ_LO]];  // see RULE_03
        xfer     = xfer_done && st.active == DCS_RUN;
        dec      = (xfer_width == 2'h0) ? 24'h000001 :             // see RULE_18
                   (xfer_width == 2'h1) ? 24'h000002 : 24'h000004;
        ctz_ev   = xfer && st.cnt <= dec;                          // see RULE_18
        abort_ev = ahb_abort && st.active == DCS_RUN;
        fall_ev  = st.active == DCS_RUN &&
                   (abort_ev || (ctz_ev && !st.ctrl[`DCS_B_RLD_EN]) || !st.ctrl[`DCS_B_EN]);
        to_lim   = 10'h001 << ({1'b0, st.ctrl[`DCS_B_PER_HI:`DCS_B_PER_LO]} + 4'(`DCS_TO_BASE_SH));
        tick     = dcs_tick(st.ctrl[`DCS_B_PRESC_HI:`DCS_B_PRESC_LO], st.pre);

        // APB slave: one wait state, then data and error stand with pready.
        next_st.pready = psel & penable & ~st.pready;
        if (psel && penable && !st.pready) begin
            next_st.prdata  = pwrite ? 32'h00000000 : dcs_rd(st, paddr);
            next_st.pslverr = !(paddr == `DCS_OFF_CTRL || paddr == `DCS_OFF_STAT ||
                                paddr == `DCS_OFF_CNT || paddr == `DCS_OFF_CRLD);
        end

        // Software writes; hardware sets below take precedence.
        if (wr_en) begin
            unique case (paddr)
                `DCS_OFF_CTRL: next_st.ctrl = pwdata & `DCS_CTRL_MASK;
                `DCS_OFF_STAT: begin
                    if (pwdata[`DCS_S_TO])   next_st.to_flag   = 1'b0;  // see RULE_08
                    if (pwdata[`DCS_S_BERR]) next_st.berr_flag = 1'b0;  // see RULE_09
                    if (pwdata[`DCS_S_RLD])  next_st.rld_flag  = 1'b0;  // see RULE_10
                    if (pwdata[`DCS_S_CTZ])  next_st.ctz_flag  = 1'b0;  // see RULE_11
                    if (pwdata[`DCS_S_ACT])  next_st.dis_flag  = 1'b0;
                end
                `DCS_OFF_CNT: begin
                    if (st.active == DCS_IDLE) begin
                        next_st.cnt = pwdata[23:0];  // see RULE_13
                    end
                end
                `DCS_OFF_CRLD: next_st.cnt_rld = pwdata[23:0];
                default: ;
            endcase
        end

        // Channel sequencing.
        unique case (st.active)
            DCS_IDLE: begin
                next_st.started = 1'b0;
                if (st.ctrl[`DCS_B_EN] && st.cnt != 24'h000000) begin
                    next_st.active  = DCS_RUN;                        // see RULE_13
                    next_st.started = !st.ctrl[`DCS_B_WAIT];          // see RULE_02
                end
            end
            DCS_RUN: begin
                if (sel_req) begin
                    next_st.started = 1'b1;                           // see RULE_19
                end
                if (xfer) begin
                    next_st.cnt = st.cnt - dec;                       // see RULE_18
                end
                if (ctz_ev) begin
                    next_st.ctz_flag = 1'b1;                          // see RULE_11
                    if (st.ctrl[`DCS_B_RLD_EN]) begin
                        next_st.cnt          = st.cnt_rld;            // see RULE_06
                        next_st.reload_pulse = 1'b1;                  // see RULE_06
                        next_st.rld_flag     = 1'b1;                  // see RULE_10
                    end
                end
                if (abort_ev) begin
                    next_st.berr_flag = 1'b1;                         // see RULE_09
                end
                if (fall_ev) begin
                    next_st.active   = DCS_IDLE;                      // see RULE_09
                    next_st.ctrl[`DCS_B_EN] = 1'b0;                   // see RULE_07
                    next_st.dis_flag = 1'b1;                          // see RULE_16
                    next_st.started  = 1'b0;
                end
            end
        endcase

        // Timeout timer on the prescaled clock.
        next_st.pre = st.pre + 24'h000001;                            // see RULE_17
        if (st.active == DCS_IDLE || !st.started || xfer ||
            st.ctrl[`DCS_B_PRESC_HI:`DCS_B_PRESC_LO] == 2'h0) begin
            next_st.tmr = 10'h000;                                    // see RULE_17
        end else if (tick) begin
            if (st.tmr == to_lim - 10'h001) begin
                next_st.tmr     = 10'h000;
                next_st.to_flag = 1'b1;                               // see RULE_01
            end else begin
                next_st.tmr = st.tmr + 10'h001;                       // see RULE_01
            end
        end

        // Pending is the OR of the sticky flags; count zero and reload flags are gated by the count zero enable, the disable flag by its enable.
        pend_calc = st.to_flag | st.berr_flag |                       // see RULE_20
                    (st.ctrl[`DCS_B_COUNT_ZERO_IRQ_ENABLE] & (st.ctz_flag | st.rld_flag)) |  // see RULE_15
                    (st.ctrl[`DCS_B_DISABLE_IRQ_ENABLE] & st.dis_flag);           // see RULE_16
        next_st.pend = pend_calc;                                     // see RULE_12

        // Arbitration among all channels, this one included.
        next_st.chan_req = st.active == DCS_RUN && sel_req;
        arb_r = '0;
        arb_p = '0;
        arb_r[NCH-1:0]   = peer_req;
        arb_p[2*NCH-1:0] = peer_pri;
        arb_r[CH_IDX]    = st.chan_req;
        arb_p[2*CH_IDX +: 2] = st.ctrl[`DCS_B_PRI_HI:`DCS_B_PRI_LO];  // see RULE_04
        next_st.grant = dcs_arb(arb_r, arb_p, st.rr_ptr);             // see RULE_05
        for (int i = 0; i < NCH; i++) begin
            if (next_st.grant[i]) begin
                next_st.rr_ptr = 3'((i + 1) % NCH);                   // see RULE_05
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign chan_req     = st.chan_req;
    assign chan_active  = st.active;
    assign reload_pulse = st.reload_pulse;
    assign grant        = st.grant[NCH-1:0];

    a_en_autoclr: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_07
        $fell(st.active) |-> !st.ctrl[`DCS_B_EN])
        else $error("Enable still set after the channel stopped.");

    a_berr_stop: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_09
        ahb_abort && st.active == DCS_RUN |=> st.berr_flag && st.active == DCS_IDLE)
        else $error("Abort did not flag an error and stop the channel.");

    a_to_sticky: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_08
        st.to_flag && !(wr_stat && pwdata[`DCS_S_TO]) |=> st.to_flag)
        else $error("Timeout flag dropped without a write of one.");

    a_ctz_set: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_11
        ctz_ev |=> st.ctz_flag)
        else $error("Count zero did not set its flag.");

    a_reload_load: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_06
        ctz_ev && st.ctrl[`DCS_B_RLD_EN] |=> st.cnt == $past(st.cnt_rld) && st.rld_flag && st.reload_pulse)
        else $error("Reload did not load the count and set its flag.");

    a_pend_track: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_20
        ##1 st.pend == $past(st.to_flag | st.berr_flag |
            (st.ctrl[`DCS_B_COUNT_ZERO_IRQ_ENABLE] & (st.ctz_flag | st.rld_flag)) | (st.ctrl[`DCS_B_DISABLE_IRQ_ENABLE] & st.dis_flag)))
        else $error("Pending does not follow the gated flags.");

    a_tmr_off: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_17
        st.ctrl[`DCS_B_PRESC_HI:`DCS_B_PRESC_LO] == 2'h0 |=> st.tmr == 10'h000)
        else $error("Timer counted while the prescaler is off.");

    a_grant_one: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_05
        $onehot0(st.grant) && (st.grant == 8'h00 || $past(arb_r) != 8'h00))
        else $error("Grant is not one-hot or came without a request.");

    a_apb_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        psel && penable && !st.pready |=> st.pready ##1 !st.pready)
        else $error("APB answer not exactly one cycle after access start.");

    a_period_lim: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_01
        st.active == DCS_RUN |-> to_lim == (10'h004 << st.ctrl[`DCS_B_PER_HI:`DCS_B_PER_LO]))
        else $error("Timeout limit does not match the period code.");

    a_start_now: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_02
        st.active == DCS_IDLE && st.ctrl[`DCS_B_EN] && st.cnt != 24'h000000 &&
        !st.ctrl[`DCS_B_WAIT] |=> st.started)
        else $error("Timer did not start at once without the wait bit.");

    a_start_wait: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_02
        st.active == DCS_IDLE && st.ctrl[`DCS_B_EN] && st.cnt != 24'h000000 &&
        st.ctrl[`DCS_B_WAIT] |=> !st.started)
        else $error("Timer started although the wait bit is set.");

    a_req_pick: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_03
        st.active == DCS_RUN && req_vec[st.ctrl[`DCS_B_REQ_HI:`DCS_B_REQ_LO]] |=> st.chan_req)
        else $error("Selected request line did not raise the channel request.");

    a_req_start: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_19
        st.active == DCS_RUN && sel_req && !fall_ev |=> st.started)
        else $error("Selected request did not start the timer.");

    a_run_start: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_13
        st.active == DCS_IDLE && st.ctrl[`DCS_B_EN] && st.cnt != 24'h000000 |=> st.active == DCS_RUN)
        else $error("Enabled channel with a count did not start.");

    a_cnt_hold: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_13
        st.active == DCS_RUN && !xfer |=> $stable(st.cnt))
        else $error("Count changed while running without a transfer.");

    a_cnt_step: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_18
        xfer && !ctz_ev |=> st.cnt == $past(st.cnt) - $past(dec))
        else $error("Count did not drop by the transfer width.");

    a_ctz_pend: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_15
        st.ctz_flag && st.ctrl[`DCS_B_COUNT_ZERO_IRQ_ENABLE] |=> st.pend)
        else $error("Enabled count zero flag did not raise pending.");

    a_dis_pend: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_16
        $fell(st.active) && st.ctrl[`DCS_B_DISABLE_IRQ_ENABLE] |=> st.pend)
        else $error("Enabled stop did not raise pending.");

    a_pend_clear: assert property (@(posedge mclk) disable iff (!rst_n)  // see RULE_12
        !(st.to_flag || st.berr_flag || st.rld_flag || st.ctz_flag || st.dis_flag) |=> !st.pend)
        else $error("Pending set with no flag outstanding.");

endmodule // dcs_channel

// *** dcs_bus_model.sv ***
`timescale 1ns/1ps
// Far side of the channel: bus fabric and peripherals that move the data.
module dcs_bus_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       chan_active,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [1:0] width,
    input  wire logic       abort_cmd,
    output logic            xfer_done,
    output logic [1:0]      xfer_width,
    output logic            ahb_abort
);
    logic [1:0] ph;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph         <= 2'h0;
            xfer_done  <= 1'b0;
            xfer_width <= 2'h0;
            ahb_abort  <= 1'b0;
        end else begin
            ph         <= ph + 2'h1;
            // Slow mode gives one access in four cycles.
            xfer_done  <= go && chan_active && (!slow || ph == 2'h0);
            // Width lines show a changing pattern outside a transfer run.
            xfer_width <= (go && chan_active) ? width : ~xfer_width;
            ahb_abort  <= abort_cmd && chan_active;
        end
    end
endmodule // dcs_bus_model

// *** dma_channel_ctrl_status_tb.sv ***
`timescale 1ns/1ps
module dma_channel_ctrl_status_tb;
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        er;
    } dcs_row_t;
    logic        mclk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, re;
    logic        xfer_done, ahb_abort, chan_req, chan_active, reload_pulse, go, slow, abort_cmd;
    logic [1:0]  xfer_width, width;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [63:0] req_vec;
    logic [7:0]  peer_req, grant, acc;
    logic [15:0] peer_pri;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          n;
    dcs_row_t    rows [12] = '{
        '{1'b0, 12'h100, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h104, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h100, 32'hFFFFFFFE, 32'h0, 1'b0},
        '{1'b0, 12'h100, 32'h0, 32'hDF77FFFE, 1'b0},
        '{1'b1, 12'h11C, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, 12'h11C, 32'h0, 32'h00FFFFFF, 1'b0},
        '{1'b1, 12'h110, 32'h12345678, 32'h0, 1'b0},
        '{1'b0, 12'h110, 32'h0, 32'h00345678, 1'b0},
        '{1'b1, 12'h104, 32'h7F, 32'h0, 1'b0},
        '{1'b0, 12'h104, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h108, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h10C, 32'h1234, 32'h0, 1'b1}
    };

    always #12.5 mclk = ~mclk;

    dcs_channel dut_u (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_vec(req_vec), .xfer_done(xfer_done), .xfer_width(xfer_width), .ahb_abort(ahb_abort),
        .peer_req(peer_req), .peer_pri(peer_pri), .chan_req(chan_req), .chan_active(chan_active),
        .reload_pulse(reload_pulse), .grant(grant));

    dcs_bus_model bus_u (.mclk(mclk), .rst_n(rst_n), .chan_active(chan_active), .go(go), .slow(slow),
        .width(width), .abort_cmd(abort_cmd), .xfer_done(xfer_done), .xfer_width(xfer_width),
        .ahb_abort(ahb_abort));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) error_cnt++;
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask

    task automatic st(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, 12'h104, 32'h0);
        chk("status", rq & m, e);
    endtask

    // Lets the channel start, then waits boundedly for it to stop.
    task automatic wait_idle;
        wt(2);
        n = 0;
        while (chan_active !== 1'b0 && n < 400) begin
            @(posedge mclk);
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        req_vec = 64'h0; peer_req = 8'h0; peer_pri = 16'h0; go = 1'b0; slow = 1'b0;
        width = 2'h0; abort_cmd = 1'b0;
        wt(10);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("pslverr", {31'h0, re}, {31'h0, rows[i].er});
            if (!rows[i].wr) chk("rdata", rq, rows[i].e);
        end
        apb(1'b1, 12'h110, 32'h6);
        width <= 2'h1;
        go    <= 1'b1;
        apb(1'b1, 12'h100, 32'h80000009);
        wait_idle();
        go <= 1'b0;
        st(32'h7F, 32'h6);
        apb(1'b0, 12'h100, 32'h0);
        chk("ctrl", rq, 32'h80000008);
        apb(1'b0, 12'h110, 32'h0);
        chk("count", rq, 32'h0);
        apb(1'b1, 12'h104, 32'h4);
        st(32'h7F, 32'h0);
        apb(1'b1, 12'h11C, 32'h8);
        apb(1'b1, 12'h110, 32'h4);
        width <= 2'h2;
        slow  <= 1'b1;
        go    <= 1'b1;
        apb(1'b1, 12'h100, 32'h3);
        n = 0;
        while (reload_pulse !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        go <= 1'b0;
        st(32'h4B, 32'h9);
        apb(1'b0, 12'h110, 32'h0);
        chk("count", rq, 32'h8);
        abort_cmd <= 1'b1;
        wt(1);
        abort_cmd <= 1'b0;
        wait_idle();
        st(32'h13, 32'h12);
        apb(1'b0, 12'h100, 32'h0);
        chk("enable", rq & 32'h1, 32'h0);
        apb(1'b1, 12'h104, 32'h7F);
        apb(1'b1, 12'h110, 32'h64);
        apb(1'b1, 12'h100, 32'h4001);
        wt(512);
        st(32'h40, 32'h0);
        wt(768);
        st(32'h41, 32'h41);
        apb(1'b1, 12'h104, 32'h40);
        st(32'h40, 32'h0);
        apb(1'b1, 12'h100, 32'h0);
        apb(1'b1, 12'h104, 32'h7F);
        req_vec[6] <= 1'b1;
        apb(1'b1, 12'h100, 32'h4459);
        wt(1400);
        st(32'h40, 32'h0);
        chk("chan_req", {31'h0, chan_req}, 32'h0);
        req_vec[5] <= 1'b1;
        wt(3);
        chk("chan_req", {31'h0, chan_req}, 32'h1);
        peer_req <= 8'h02;
        peer_pri <= 16'h0004;
        wt(3);
        chk("grant", {24'h0, grant}, 32'h2);
        peer_pri <= 16'h000C;
        wt(3);
        chk("grant", {24'h0, grant}, 32'h1);
        peer_pri <= 16'h0008;
        acc = 8'h0;
        repeat (4) begin
            @(posedge mclk);
            acc = acc | grant;
        end
        chk("grant", {24'h0, acc}, 32'h3);
        wt(1200);
        st(32'h40, 32'h40);
        apb(1'b1, 12'h100, 32'h0);
        apb(1'b1, 12'h104, 32'h7F);
        apb(1'b1, 12'h100, 32'h1);
        wt(1400);
        st(32'h41, 32'h1);
        apb(1'b1, 12'h100, 32'h40000000);
        st(32'h3, 32'h2);
        apb(1'b1, 12'h104, 32'h1);
        st(32'h3, 32'h0);
        apb(1'b1, 12'h100, 32'h40000001);
        wt(2);
        chk("active", {31'h0, chan_active}, 32'h1);
        rst_n <= 1'b0;
        wt(2);
        chk("active", {31'h0, chan_active}, 32'h0);
        rst_n <= 1'b1;
        apb(1'b0, 12'h100, 32'h0);
        chk("ctrl", rq, 32'h0);
        apb(1'b0, 12'h110, 32'h0);
        chk("count", rq, 32'h0);
        st(32'h7F, 32'h0);
        give_verdict();
    end

    initial begin
        wt(30000);
        error_cnt++;
        give_verdict();
    end
endmodule // dma_channel_ctrl_status_tb
